// file: rtl/dsb_pkg.sv
// Purpose: Shared constants and types for the four-beat double-data-rate SRAM bus-cycle block.
// Assumes: Link clocks and pins are sampled by the 50 MHz system clock.
// Notes:   Behaviour list below; the logic sits in dsb_sram_core.
// Behaviour
// - Beats two to four advance the two low address bits in wrapping order.
// - A burst ends by itself after four words; no stop command exists.
// - The bus-cycle state machine changes state only on K rises.
// - Load strobe low starts an access; high is a no-op with data pins released.
// - Write: load and direction low; four words captured on alternating input clock rises.
// - Read: load low, direction high; four words driven on alternating output clock rises.
// - Read data launches from output clocks, or input clocks when both output clocks stay high.
// - Echo clocks follow the read launch clocks and run freely, even when released.
// - Data bus is 18 bits narrow or 36 bits wide.
// - A byte lane is written on a beat only when its write enable is low.
// - Address inputs are ignored while deselected or mid-burst; sampled only with a load.
package dsb_pkg;

  localparam int DSB_ADDR_W     = 20;
  localparam int DSB_DATA_W     = 18;
  localparam int DSB_LANE_W     = 9;
  localparam int DSB_BURST_LEN  = 4;
  localparam int DSB_FIFO_DEPTH = 8;
  localparam int DSB_SYNC_FIXED = 6;

  localparam logic [1:0] DSB_BEAT_FIRST = 2'h0;
  localparam logic [1:0] DSB_BEAT_LAST  = 2'(DSB_BURST_LEN - 1);
  localparam logic       DSB_OE_RST     = 1'b0;
  localparam logic       DSB_ECHO_RST   = 1'b0;

  typedef enum logic [1:0] {
    DSB_ST_IDLE  = 2'b00,
    DSB_ST_WRITE = 2'b01,
    DSB_ST_READ  = 2'b10
  } dsb_state_t;

  typedef struct packed {
    logic load_n;
    logic rd;
  } dsb_ctl_t;

endpackage

// file: rtl/dsb_sram_core.sv
// Purpose: Bus-cycle logic, write buffer and storage of a four-beat DDR SRAM.
// Assumes: K, K_N, C, C_N and all pins are asynchronous to CLK and slow against it.
// Notes:   Reset is local only; the storage array itself is not cleared.
`timescale 1ns/1ps

module dsb_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 8
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] store [DEPTH];
  logic [AW:0]  wr_ptr_r;
  logic [AW:0]  rd_ptr_r;
  logic         push;
  logic         pop;

  assign in_ready  = (wr_ptr_r[AW] == rd_ptr_r[AW]) || (wr_ptr_r[AW-1:0] != rd_ptr_r[AW-1:0]);
  assign out_valid = wr_ptr_r != rd_ptr_r;
  assign out_data  = store[rd_ptr_r[AW-1:0]];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge clk) begin
    if (push) begin
      store[wr_ptr_r[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
    end else begin
      wr_ptr_r <= push ? AW'(1) + wr_ptr_r : wr_ptr_r;
      rd_ptr_r <= pop ? AW'(1) + rd_ptr_r : rd_ptr_r;
    end
  end
endmodule

module dsb_sram_core import dsb_pkg::*; #(
  parameter int ADDR_W     = DSB_ADDR_W,
  parameter int DATA_W     = DSB_DATA_W,
  parameter int FIFO_DEPTH = DSB_FIFO_DEPTH
) (
  input  wire logic                          CLK,
  input  wire logic                          RST_N,
  input  wire logic                          K,
  input  wire logic                          K_N,
  input  wire logic                          C,
  input  wire logic                          C_N,
  input  wire logic                          LOAD_STROBE_N,
  input  wire logic                          RW,
  input  wire logic [ADDR_W-1:0]             ADDR,
  input  wire logic [DATA_W/DSB_LANE_W-1:0]  BYTE_WRITE_N,
  input  wire logic [DATA_W-1:0]             DQ_I,
  output logic      [DATA_W-1:0]             DQ_O,
  output logic                               DQ_OE,
  output logic                               ECHO_TIMING_POS,
  output logic                               ECHO_TIMING_NEG
);
  localparam int NBW = DATA_W / DSB_LANE_W;
  localparam int SW  = DSB_SYNC_FIXED + ADDR_W + NBW + DATA_W;
  localparam int FW  = ADDR_W + NBW + DATA_W;

  function automatic logic [ADDR_W-1:0] burst_addr(input logic [ADDR_W-1:0] base, input logic [1:0] beat);
    burst_addr = {base[ADDR_W-1:2], 2'(base[1:0] + beat)};
  endfunction

  function automatic logic [DATA_W-1:0] lane_merge(input logic [DATA_W-1:0] old_w, input logic [DATA_W-1:0] new_w,
                                                   input logic [NBW-1:0] bw_n);
    lane_merge = old_w;
    for (int i = 0; i < NBW; i++) begin
      if (!bw_n[i]) begin
        lane_merge[i*DSB_LANE_W +: DSB_LANE_W] = new_w[i*DSB_LANE_W +: DSB_LANE_W];
      end
    end
  endfunction

  // Storage
  logic [DATA_W-1:0] mem [2**ADDR_W];

  // Two-stage synchroniser, plus a third stage for edge finding
  logic [SW-1:0] s1_r;
  logic [SW-1:0] s2_r;
  logic [SW-1:0] s3_r;
  logic [SW-1:0] raw;

  assign raw = {K, K_N, C, C_N, LOAD_STROBE_N, RW, ADDR, BYTE_WRITE_N, DQ_I};

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
    end else begin
      s1_r <= raw;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // Fields; data and control come from the older stage so they are the values set up before the edge
  logic              k_rise;
  logic              kn_rise;
  logic              c_rise;
  logic              cn_rise;
  logic              c_held;
  logic              launch_pos;
  logic              launch_neg;
  dsb_ctl_t          ctl;
  logic [ADDR_W-1:0] addr_s;
  logic [NBW-1:0]    bw_s;
  logic [DATA_W-1:0] dq_s;

  assign k_rise     = s2_r[SW-1] && !s3_r[SW-1];
  assign kn_rise    = s2_r[SW-2] && !s3_r[SW-2];
  assign c_rise     = s2_r[SW-3] && !s3_r[SW-3];
  assign cn_rise    = s2_r[SW-4] && !s3_r[SW-4];
  assign c_held     = s2_r[SW-3] && s2_r[SW-4] && s3_r[SW-3] && s3_r[SW-4];
  assign launch_pos = c_held ? k_rise : c_rise;
  assign launch_neg = c_held ? kn_rise : cn_rise;
  assign ctl        = '{load_n: s3_r[SW-5], rd: s3_r[SW-6]};
  assign addr_s     = s3_r[DATA_W+NBW +: ADDR_W];
  assign bw_s       = s3_r[DATA_W +: NBW];
  assign dq_s       = s3_r[DATA_W-1:0];

  // Bus-cycle state machine, stepped by K rises only
  dsb_state_t state_r;
  dsb_state_t state_nxt;
  logic       half_r;
  logic       mid_burst;
  logic       load_ok;
  logic       wr_load;
  logic       rd_load;

  assign mid_burst = (state_r != DSB_ST_IDLE) && !half_r;
  assign load_ok   = k_rise && !mid_burst && !ctl.load_n;
  assign wr_load   = load_ok && !ctl.rd;
  assign rd_load   = load_ok && ctl.rd;

  always_comb begin
    state_nxt = state_r;
    if (k_rise && !mid_burst) begin
      case (state_r)
        default: begin
          if (ctl.load_n) begin
            state_nxt = DSB_ST_IDLE;
          end else begin
            state_nxt = ctl.rd ? DSB_ST_READ : DSB_ST_WRITE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      state_r <= DSB_ST_IDLE;
      half_r  <= 1'b0;
    end else if (k_rise) begin
      state_r <= state_nxt;
      half_r  <= mid_burst;
    end
  end

  // Write beats: K rise, K_N rise, K rise, K_N rise
  logic              wr_act_r;
  logic [1:0]        wbeat_r;
  logic [ADDR_W-1:0] wbase_r;
  logic              wr_beat;
  logic              push;
  logic [ADDR_W-1:0] push_addr;

  assign wr_beat   = wr_act_r && (wbeat_r[0] ? kn_rise : k_rise);
  assign push      = wr_load || wr_beat;
  assign push_addr = wr_load ? addr_s : burst_addr(wbase_r, wbeat_r);

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      wr_act_r <= 1'b0;
      wbeat_r  <= DSB_BEAT_FIRST;
      wbase_r  <= '0;
    end else if (wr_load) begin
      wr_act_r <= 1'b1;
      wbeat_r  <= 2'(DSB_BEAT_FIRST + 2'h1);
      wbase_r  <= addr_s;
    end else if (wr_beat) begin
      wr_act_r <= wbeat_r != DSB_BEAT_LAST;
      wbeat_r  <= 2'(wbeat_r + 2'h1);
    end
  end

  // Write buffer; a beat that meets a full buffer is lost, which the drain rate makes unreachable
  logic          fifo_out_valid;
  logic          drain_ready;
  logic [FW-1:0] fifo_out;
  logic          launch;

  assign drain_ready = !launch; // Array port is shared with read launch

  dsb_fifo #(.W(FW), .DEPTH(FIFO_DEPTH)) u_wbuf (
    .clk       (CLK),
    .rst_n     (RST_N),
    .in_valid  (push),
    .in_ready  (),
    .in_data   ({push_addr, bw_s, dq_s}),
    .out_valid (fifo_out_valid),
    .out_ready (drain_ready),
    .out_data  (fifo_out)
  );

  always_ff @(posedge CLK) begin
    if (fifo_out_valid && drain_ready) begin
      mem[fifo_out[FW-1 -: ADDR_W]] <= lane_merge(mem[fifo_out[FW-1 -: ADDR_W]], fifo_out[DATA_W-1:0],
                                                  fifo_out[DATA_W +: NBW]);
    end
  end

  // Read beats on launch clock rises, even beats on the positive one
  logic              rd_act_r;
  logic [1:0]        rbeat_r;
  logic [ADDR_W-1:0] rbase_r;
  logic [1:0]        rd_beat;
  logic [ADDR_W-1:0] rd_base;

  assign rd_beat = rd_load ? DSB_BEAT_FIRST : rbeat_r;
  assign rd_base = rd_load ? addr_s : rbase_r;
  assign launch  = (rd_load || rd_act_r) && (rd_beat[0] ? launch_neg : launch_pos);

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      rd_act_r <= 1'b0;
      rbeat_r  <= DSB_BEAT_FIRST;
      rbase_r  <= '0;
    end else begin
      if (rd_load) begin
        rbase_r <= addr_s;
      end
      if (launch) begin
        rd_act_r <= rd_beat != DSB_BEAT_LAST;
        rbeat_r  <= 2'(rd_beat + 2'h1);
      end else if (rd_load) begin
        rd_act_r <= 1'b1;
        rbeat_r  <= DSB_BEAT_FIRST;
      end
    end
  end

  // Pin drivers
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      DQ_O            <= '0;
      DQ_OE           <= DSB_OE_RST;
      ECHO_TIMING_POS <= DSB_ECHO_RST;
      ECHO_TIMING_NEG <= DSB_ECHO_RST;
    end else begin
      if (launch) begin
        DQ_O  <= mem[burst_addr(rd_base, rd_beat)];
        DQ_OE <= 1'b1;
      end else if (launch_pos || launch_neg) begin
        DQ_OE <= 1'b0;
      end
      ECHO_TIMING_POS <= c_held ? s2_r[SW-1] : s2_r[SW-3];
      ECHO_TIMING_NEG <= c_held ? s2_r[SW-2] : s2_r[SW-4];
    end
  end
endmodule

// file: testbench/dsb_core_sva.sv
// Purpose: Port checks of the four-beat bus-cycle block
// Assumes: Output clocks held high or in step with the input clocks
// Notes:   Windows allow for pin synchroniser latency
`timescale 1ns/1ps

module dsb_core_sva import dsb_pkg::*; #(
  parameter int ADDR_W = DSB_ADDR_W,
  parameter int DATA_W = DSB_DATA_W
) (
  input wire logic                         CLK,
  input wire logic                         RST_N,
  input wire logic                         K,
  input wire logic                         K_N,
  input wire logic                         LOAD_STROBE_N,
  input wire logic                         RW,
  input wire logic [DATA_W-1:0]            DQ_O,
  input wire logic                         DQ_OE,
  input wire logic                         ECHO_TIMING_POS,
  input wire logic                         ECHO_TIMING_NEG
);
  logic       k_q_r;
  logic       kn_q_r;
  logic [5:0] k_cnt_r;
  logic [5:0] e_cnt_r;
  logic [5:0] rd_cnt_r;
  wire        k_rise  = K & ~k_q_r;
  wire        kn_rise = K_N & ~kn_q_r;

  // Counters saturate so long idle stays idle
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      {k_q_r, kn_q_r} <= 2'h0;
      {k_cnt_r, e_cnt_r, rd_cnt_r} <= {3{6'h3f}};
    end else begin
      {k_q_r, kn_q_r} <= {K, K_N};
      k_cnt_r  <= k_rise ? 6'h00 : k_cnt_r + 6'(k_cnt_r != 6'h3f);
      e_cnt_r  <= (k_rise | kn_rise) ? 6'h00 : e_cnt_r + 6'(e_cnt_r != 6'h3f);
      rd_cnt_r <= (k_rise & ~LOAD_STROBE_N & RW) ? 6'h00 : rd_cnt_r + 6'(rd_cnt_r != 6'h3f);
    end
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);

  property p_echo_pos; $rose(K) |-> ##[2:6] ECHO_TIMING_POS; endproperty
  property p_echo_neg; $rose(K_N) |-> ##[2:6] ECHO_TIMING_NEG; endproperty
  property p_oe_start; $rose(DQ_OE) |-> rd_cnt_r inside {[6'h02:6'h07]}; endproperty
  property p_oe_bound; DQ_OE |-> rd_cnt_r <= 6'h1c; endproperty
  property p_oe_edge; $changed(DQ_OE) |-> k_cnt_r inside {[6'h02:6'h07]}; endproperty
  property p_dq_edge; $changed(DQ_O) |-> e_cnt_r inside {[6'h02:6'h07]}; endproperty
  property p_dq_owned; $changed(DQ_O) |-> DQ_OE; endproperty
  property p_nop_quiet; $rose(K) && LOAD_STROBE_N && rd_cnt_r >= 6'h18 |-> (!DQ_OE)[*8]; endproperty
  a_echo_pos: assert property (p_echo_pos) else $error("echo pos late");
  a_echo_neg: assert property (p_echo_neg) else $error("echo neg late");
  a_oe_start: assert property (p_oe_start) else $error("read start mistimed");
  a_oe_bound: assert property (p_oe_bound) else $error("burst overran");
  a_oe_edge: assert property (p_oe_edge) else $error("enable off input clock");
  a_dq_edge: assert property (p_dq_edge) else $error("data off launch clock");
  a_dq_owned: assert property (p_dq_owned) else $error("data moved undriven");
  a_nop_quiet: assert property (p_nop_quiet) else $error("driven on idle");
  c_read: cover property ($rose(DQ_OE));
  c_write: cover property ($rose(K) && !LOAD_STROBE_N && !RW);
  c_nop: cover property ($rose(K) && LOAD_STROBE_N);
endmodule

bind dsb_sram_core dsb_core_sva #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) i_sva (.CLK(CLK), .RST_N(RST_N), .K(K),
  .K_N(K_N), .LOAD_STROBE_N(LOAD_STROBE_N), .RW(RW), .DQ_O(DQ_O), .DQ_OE(DQ_OE),
  .ECHO_TIMING_POS(ECHO_TIMING_POS), .ECHO_TIMING_NEG(ECHO_TIMING_NEG));

// file: testbench/dsb_ctl_model.sv
// Purpose: Controller model driving link clocks, commands, write data
// Assumes: Free-running input clocks of 160 ns
// Notes:   Released lines get inverted values, not held ones
`timescale 1ns/1ps

module dsb_ctl_model #(
  parameter int AW = 6,
  parameter int DW = 18,
  parameter int NB = 2
) (
  output logic          K,
  output logic          K_N,
  output logic          C,
  output logic          C_N,
  output logic          LOAD_STROBE_N,
  output logic          RW,
  output logic [AW-1:0] ADDR,
  output logic [NB-1:0] BYTE_WRITE_N,
  output logic [DW-1:0] DQ_I
);
  // In step with K until held high; once held they never toggle again
  logic c_free = 1'b1;

  assign C   = c_free ? K : 1'b1;
  assign C_N = c_free ? K_N : 1'b1;

  initial begin
    {K, K_N, LOAD_STROBE_N, RW, ADDR, BYTE_WRITE_N, DQ_I} = {3'b011, 1'b0, {AW{1'b0}}, {NB{1'b1}}, {DW{1'b0}}};
    #3;
    forever begin
      #80 K = ~K;
      K_N = ~K_N;
    end
  end

  // Changes land midway between edges for setup and hold
  task automatic idle(input logic [AW-1:0] a, input logic r);
    @(negedge K);
    #40 {LOAD_STROBE_N, RW, ADDR, DQ_I} = {1'b1, r, a, ~DQ_I};
  endtask

  task automatic burst(input logic r, input logic [AW-1:0] a, input logic [4*DW-1:0] d, input logic [4*NB-1:0] bw);
    @(negedge K);
    #40 {LOAD_STROBE_N, RW, ADDR} = {1'b0, r, a};
    for (int n = 0; n < 4; n++) begin
      if (n > 0)
        #80 {LOAD_STROBE_N, RW, ADDR} = {(n == 2) ? 1'($urandom) : 1'b1, ~r, ~a};
      {DQ_I, BYTE_WRITE_N} = {d[n*DW +: DW], bw[n*NB +: NB]};
    end
  endtask

  // Switch on a K rise, where C already sits high and C_N stays high, so no stray edge
  task automatic hold_out_clocks();
    @(posedge K);
    c_free = 1'b0;
  endtask
endmodule

// file: testbench/testbench.sv
// Purpose: Random and corner bursts with read-back scoreboard
// Assumes: Address width cut to 6 bits
// Notes:   Samples land 70 ns after each input clock rise, before the next one
`timescale 1ns/1ps

module testbench import dsb_pkg::*;;
  localparam int AW = 6;
  localparam int DW = DSB_DATA_W;
  localparam int NB = DW / DSB_LANE_W;
  logic          CLK, RST_N, K, K_N, C, C_N, LOAD_STROBE_N, RW, DQ_OE, ECHO_TIMING_POS, ECHO_TIMING_NEG, mon_on;
  logic [AW-1:0] ADDR;
  logic [NB-1:0] BYTE_WRITE_N;
  logic [DW-1:0] DQ_I, DQ_O;
  logic [DW-1:0] mem [2**AW];
  logic [DW-1:0] expq [$];
  int            err_count, n_checks;

  dsb_sram_core #(.ADDR_W(AW), .DATA_W(DW), .FIFO_DEPTH(DSB_FIFO_DEPTH)) i_dut (.CLK(CLK), .RST_N(RST_N), .K(K),
    .K_N(K_N), .C(C), .C_N(C_N), .LOAD_STROBE_N(LOAD_STROBE_N), .RW(RW), .ADDR(ADDR), .BYTE_WRITE_N(BYTE_WRITE_N),
    .DQ_I(DQ_I), .DQ_O(DQ_O), .DQ_OE(DQ_OE), .ECHO_TIMING_POS(ECHO_TIMING_POS), .ECHO_TIMING_NEG(ECHO_TIMING_NEG));
  dsb_ctl_model #(.AW(AW), .DW(DW), .NB(NB)) i_ctl (.K(K), .K_N(K_N), .C(C), .C_N(C_N),
    .LOAD_STROBE_N(LOAD_STROBE_N), .RW(RW), .ADDR(ADDR), .BYTE_WRITE_N(BYTE_WRITE_N), .DQ_I(DQ_I));

  task automatic chk_word(input string nm, input logic [DW-1:0] e, input logic [DW-1:0] g);
    n_checks++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_flag(input string nm, input logic [1:0] e, input logic [1:0] g);
    n_checks++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %s expected %b seen %b", nm, e, g);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  function automatic logic [DW-1:0] merge(input logic [DW-1:0] o, input logic [DW-1:0] w, input logic [NB-1:0] bw);
    for (int l = 0; l < NB; l++)
      if (!bw[l]) o[l*DSB_LANE_W +: DSB_LANE_W] = w[l*DSB_LANE_W +: DSB_LANE_W];
    return o;
  endfunction

  task automatic do_burst(input logic r, input logic [AW-1:0] a, input logic [4*NB-1:0] bw);
    logic [4*DW-1:0] d;
    logic [AW-1:0]   ba;
    logic [DW-1:0]   e [4];
    for (int n = 0; n < 4; n++) begin
      d[n*DW +: DW] = DW'({$urandom, $urandom});
      ba = {a[AW-1:2], 2'(a[1:0] + n)};
      if (r) e[n] = mem[ba];
      else mem[ba] = merge(mem[ba], d[n*DW +: DW], bw[n*NB +: NB]);
    end
    fork
      i_ctl.burst(r, a, d, bw);
      begin
        @(negedge K);
        #100;
        if (r) for (int n = 0; n < 4; n++) expq.push_back(e[n]);
      end
    join
  endtask

  initial begin
    CLK = 1'b0;
    forever #10 CLK = ~CLK;
  end

  // Run needs about 33 us
  initial begin
    #200000;
    err_count++;
    stop_test();
  end

  // Outputs settle about 3 CLK after a pin edge; the next edge follows 80 ns on
  initial begin
    forever begin
      @(posedge K or posedge K_N);
      #70;
      if (mon_on) begin
        chk_flag("echo", {K, ~K}, {ECHO_TIMING_POS, ECHO_TIMING_NEG});
        if (expq.size() > 0) begin
          chk_flag("oe", 2'b01, {1'b0, DQ_OE});
          chk_word("rdata", expq.pop_front(), DQ_O);
        end else
          chk_flag("oe", 2'b00, {1'b0, DQ_OE});
      end
    end
  end

  initial begin
    {RST_N, mon_on, err_count, n_checks} = '0;
    void'($urandom(54));
    repeat (5) @(posedge CLK);
    #2 RST_N = 1'b1;
    repeat (20) @(posedge CLK);
    #2 mon_on = 1'b1;
    for (int i = 0; i < 2**AW/4; i++) do_burst(1'b0, AW'(i*4 + i%4), '0);
    $display("test fill done");
    for (int i = 0; i < 2**AW/4; i++) do_burst(1'b1, AW'(i*4 + (i+1)%4), '0);
    $display("test readback done");
    i_ctl.hold_out_clocks();
    for (int i = 0; i < 60; i++) begin
      if ($urandom_range(3) == 0) i_ctl.idle(AW'($urandom), 1'($urandom));
      do_burst(1'($urandom), AW'($urandom), (4*NB)'($urandom));
    end
    $display("test random mix done");
    repeat (4) i_ctl.idle(AW'($urandom), 1'($urandom));
    chk_flag("queue", 2'b00, {1'b0, expq.size() != 0});
    $display("test drain done");
    stop_test();
  end
endmodule
